/* File: rtl/hcpi_consts.svh */
`ifndef HCPI_CONSTS_SVH
`define HCPI_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define HCPI_OFS_GCFG 8'h02
`define HCPI_OFS_MASK0 8'h14
`define HCPI_OFS_MASK1 8'h15
`define HCPI_OFS_STAT0 8'h19
`define HCPI_OFS_STAT1 8'h1a

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define HCPI_GCFG_IRQ_LSB 0
`define HCPI_GCFG_RST 8'h00
`define HCPI_MASK_RST 8'hff
`define HCPI_IRQ_PP_HIGH 2'h0
`define HCPI_IRQ_PP_LOW 2'h1

// ----------------------------------------------------------------
// Host mode selection
// ----------------------------------------------------------------
`define HCPI_MODE_SERIAL 2'h0
`define HCPI_MODE_WRSTB 2'h1
`define HCPI_MODE_DIRSEL 2'h2

// ----------------------------------------------------------------
// Serial frame and timing
// ----------------------------------------------------------------
`define HCPI_SER_CMD_BITS 5'h08
`define HCPI_SER_FRAME_BITS 5'h10
`define HCPI_CLK_MHZ 250
`define HCPI_ACC_NS 20
`define HCPI_ACC_CYC ((`HCPI_ACC_NS * `HCPI_CLK_MHZ + 999) / 1000)

`endif

/* File: rtl/hcpi_pkg.sv */
package hcpi_pkg;

   typedef enum logic [1:0] {
      ACC_IDLE,
      ACC_WAIT,
      ACC_DONE
   } hcpi_acc_t;

endpackage

/* File: rtl/hcpi_sync.sv */
`timescale 1ns/1ps

module hcpi_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Asynchronous levels in, synchronised levels out
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } hcpi_sync_t;

   hcpi_sync_t st;
   hcpi_sync_t next_st;

   // The first stage feeds only the second stage.
   always_comb begin
      next_st = st;
      next_st.s1 = async_in;
      next_st.s2 = st.s1;
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign sync_out = st.s2;

endmodule

/* File: rtl/hcpi_top.sv */
`timescale 1ns/1ps
`include "hcpi_consts.svh"

module hcpi_top #(
   parameter int ACC_CYC = `HCPI_ACC_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Static mode selection
   input wire logic [1:0] mode_sel,
   // Chip select
   input wire logic cs_n,
   // Serial port
   input wire logic sclk,
   input wire logic ser_in,
   input wire logic ser_out_edge_sel,
   output logic ser_out,
   // Multiplexed address/data bus
   input wire logic [7:0] ad_in,
   output logic [7:0] ad_out,
   output logic ad_oe_n,
   // Write-strobe style parallel strobes
   input wire logic addr_latch_en,
   input wire logic wr_n,
   input wire logic rd_n,
   output logic ready,
   // Direction-select style parallel strobes
   input wire logic addr_strobe_m,
   input wire logic moto_data_strobe_n,
   input wire logic rw_sel,
   output logic ack_n,
   // Interrupt sources and request pin
   input wire logic [15:0] irq_src,
   output logic irq_out,
   output logic irq_oe_n
);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [17:0] pins_s;
   logic s_cs_n, s_sclk, s_sin, s_edge, s_ale, s_as, s_wr_n, s_rd_n, s_ds_n, s_rw;
   logic [7:0] s_ad;

   // Active-low pins pass the synchroniser inverted, so that its cleared stages read as idle
   // and no false access starts in the two cycles after reset.
   hcpi_sync #(.W(18)) u_sync (
      .clk(clk),
      .resetn(resetn),
      .async_in({cs_n, sclk, ser_in, ser_out_edge_sel, addr_latch_en, addr_strobe_m,
                 wr_n, rd_n, moto_data_strobe_n, rw_sel, ad_in} ^ 18'h20e00),
      .sync_out(pins_s)
   );

   assign {s_cs_n, s_sclk, s_sin, s_edge, s_ale, s_as, s_wr_n, s_rd_n, s_ds_n, s_rw, s_ad} =
      pins_s ^ 18'h20e00;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] gcfg;
      logic [15:0] mask;
      logic [15:0] stat;
      logic sclk_d;
      logic ale_d;
      logic as_d;
      logic [4:0] bit_cnt;
      logic [15:0] ser_sh;
      logic ser_rd;
      logic [7:0] rd_sh;
      logic ser_out;
      logic [7:0] addr;
      hcpi_pkg::hcpi_acc_t acc;
      logic acc_rd;
      logic [7:0] wait_cnt;
      logic [7:0] ad_out;
      logic ad_oe_n;
      logic ready;
      logic ack_n;
      logic irq_out;
      logic irq_oe_n;
   } hcpi_state_t;

   hcpi_state_t st;
   hcpi_state_t next_st;

   logic [7:0] rdata;
   logic pending;

   // ----------------------------------------------------------------
   // Register read mux
   // ----------------------------------------------------------------
   // Unmapped offsets read as zero.
   function automatic logic [7:0] reg_read(input hcpi_state_t s, input logic [7:0] a);
      logic [7:0] d;
      d = 8'h00;
      case (a)
         `HCPI_OFS_GCFG: d = s.gcfg;
         `HCPI_OFS_MASK0: d = s.mask[7:0];
         `HCPI_OFS_MASK1: d = s.mask[15:8];
         `HCPI_OFS_STAT0: d = s.stat[7:0];
         `HCPI_OFS_STAT1: d = s.stat[15:8];
         default: d = 8'h00;
      endcase
      return d;
   endfunction

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      logic sclk_rise, sclk_fall, act_edge, strobe, is_rd, do_wr;
      logic [7:0] wa, wd;
      logic [15:0] clr;
      logic [15:0] frame;
      sclk_rise = 1'b0;
      sclk_fall = 1'b0;
      act_edge = 1'b0;
      strobe = 1'b0;
      is_rd = 1'b0;
      do_wr = 1'b0;
      wa = 8'h00;
      wd = 8'h00;
      clr = 16'h0000;
      frame = 16'h0000;
      next_st = st;
      rdata = reg_read(st, st.addr);

      next_st.sclk_d = s_sclk;
      next_st.ale_d = s_ale;
      next_st.as_d = s_as;

      // Mode is decoded directly from the static selection pins.
      case (mode_sel)
         `HCPI_MODE_SERIAL: begin
            sclk_rise = s_sclk & ~st.sclk_d;
            sclk_fall = ~s_sclk & st.sclk_d;
            act_edge = s_edge ? sclk_fall : sclk_rise;
            if (s_cs_n) begin
               next_st.bit_cnt = 5'h00;
               next_st.ser_rd = 1'b0;
            end else begin
               if (act_edge && st.bit_cnt >= `HCPI_SER_CMD_BITS && st.ser_rd) begin
                  next_st.ser_out = st.rd_sh[7];
                  next_st.rd_sh = {st.rd_sh[6:0], 1'b0};
               end
               if (sclk_rise && st.bit_cnt < `HCPI_SER_FRAME_BITS) begin
                  frame = {st.ser_sh[14:0], s_sin};
                  next_st.ser_sh = frame;
                  next_st.bit_cnt = st.bit_cnt + 5'h01;
                  if (st.bit_cnt == `HCPI_SER_CMD_BITS - 5'h01) begin
                     next_st.rd_sh = reg_read(st, {1'b0, frame[6:0]});
                     next_st.ser_rd = frame[7];
                  end
                  if (st.bit_cnt == `HCPI_SER_FRAME_BITS - 5'h01 && !frame[15]) begin
                     do_wr = 1'b1;
                     wa = {1'b0, frame[14:8]};
                     wd = frame[7:0];
                  end
               end
            end
         end
         `HCPI_MODE_WRSTB: begin
            if (!s_cs_n && !s_ale && st.ale_d) begin
               next_st.addr = s_ad;
            end
            strobe = !s_cs_n && (!s_wr_n || !s_rd_n);
            is_rd = !s_rd_n;
         end
         `HCPI_MODE_DIRSEL: begin
            if (!s_cs_n && !s_as && st.as_d) begin
               next_st.addr = s_ad;
            end
            strobe = !s_cs_n && !s_ds_n;
            is_rd = s_rw;
         end
         default: begin
            strobe = 1'b0;
         end
      endcase

      // Parallel access sequencer shared by both strobe styles.
      case (st.acc)
         hcpi_pkg::ACC_IDLE: begin
            if (strobe) begin
               next_st.acc = hcpi_pkg::ACC_WAIT;
               next_st.acc_rd = is_rd;
               next_st.wait_cnt = 8'h00;
            end
         end
         hcpi_pkg::ACC_WAIT: begin
            next_st.wait_cnt = st.wait_cnt + 8'h01;
            if (!strobe) begin
               next_st.acc = hcpi_pkg::ACC_IDLE;
            end else if (st.wait_cnt >= 8'(ACC_CYC - 1)) begin
               next_st.acc = hcpi_pkg::ACC_DONE;
            end
         end
         hcpi_pkg::ACC_DONE: begin
            if (!strobe) begin
               next_st.acc = hcpi_pkg::ACC_IDLE;
               if (!st.acc_rd) begin
                  do_wr = 1'b1;
                  wa = st.addr;
                  wd = s_ad;
               end
            end
         end
         default: begin
            next_st.acc = hcpi_pkg::ACC_IDLE;
         end
      endcase

      next_st.ready = (next_st.acc != hcpi_pkg::ACC_WAIT);
      next_st.ack_n = ~((mode_sel == `HCPI_MODE_DIRSEL) && next_st.acc == hcpi_pkg::ACC_DONE);
      // Read data is driven only while the read strobe is held.
      next_st.ad_oe_n = ~(strobe && is_rd && mode_sel != `HCPI_MODE_SERIAL);
      next_st.ad_out = rdata;

      // Register writes; status bits clear by writing ones.
      if (do_wr) begin
         case (wa)
            `HCPI_OFS_GCFG: next_st.gcfg = wd;
            `HCPI_OFS_MASK0: next_st.mask[7:0] = wd;
            `HCPI_OFS_MASK1: next_st.mask[15:8] = wd;
            `HCPI_OFS_STAT0: clr[7:0] = wd;
            `HCPI_OFS_STAT1: clr[15:8] = wd;
            default: clr = 16'h0000;
         endcase
      end
      // A source event in the clearing cycle keeps its bit set.
      next_st.stat = (st.stat & ~clr) | irq_src;

      pending = |(next_st.stat & ~next_st.mask);
      case (next_st.gcfg[`HCPI_GCFG_IRQ_LSB +: 2])
         `HCPI_IRQ_PP_HIGH: begin
            next_st.irq_out = pending;
            next_st.irq_oe_n = 1'b0;
         end
         `HCPI_IRQ_PP_LOW: begin
            next_st.irq_out = ~pending;
            next_st.irq_oe_n = 1'b0;
         end
         default: begin
            next_st.irq_out = 1'b0;
            next_st.irq_oe_n = ~pending;
         end
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st <= '0;
         st.gcfg <= `HCPI_GCFG_RST;
         st.mask <= {`HCPI_MASK_RST, `HCPI_MASK_RST};
         st.sclk_d <= 1'b0;
         st.ale_d <= 1'b0;
         st.as_d <= 1'b0;
         st.acc <= hcpi_pkg::ACC_IDLE;
         st.ad_oe_n <= 1'b1;
         st.ready <= 1'b1;
         st.ack_n <= 1'b1;
         st.irq_out <= 1'b0;
         st.irq_oe_n <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign ser_out = st.ser_out;
   assign ad_out = st.ad_out;
   assign ad_oe_n = st.ad_oe_n;
   assign ready = st.ready;
   assign ack_n = st.ack_n;
   assign irq_out = st.irq_out;
   assign irq_oe_n = st.irq_oe_n;

endmodule

/* File: tb/hcpi_monitor.sv */
`timescale 1ns/1ps
`include "hcpi_consts.svh"

module hcpi_monitor #(
   parameter int ACC_CYC = 5
) (
   // Clock, reset and mode
   input wire logic clk,
   input wire logic resetn,
   input wire logic [1:0] mode_sel,
   // Host strobes
   input wire logic cs_n,
   input wire logic wr_n,
   input wire logic rd_n,
   input wire logic moto_data_strobe_n,
   input wire logic rw_sel,
   // Device answers
   input wire logic ready,
   input wire logic ack_n,
   input wire logic ad_oe_n,
   input wire logic irq_out,
   input wire logic irq_oe_n
);
   logic [7:0] lo_cnt;
   wire logic ser = mode_sel == `HCPI_MODE_SERIAL;
   wire logic wst = mode_sel == `HCPI_MODE_WRSTB;
   wire logic dir = mode_sel == `HCPI_MODE_DIRSEL;

   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) lo_cnt <= 8'h00;
      else lo_cnt <= ready ? 8'h00 : lo_cnt + 8'h01;
   end

   // Six quiet cycles leave room for the two sync flops and the output register.
   sequence s_rd_quiet; (wst && rd_n)[*6]; endsequence
   sequence s_ds_quiet; (dir && (moto_data_strobe_n || !rw_sel))[*6]; endsequence
   sequence s_ds_off; (dir && moto_data_strobe_n)[*6]; endsequence
   sequence s_cs_off; cs_n[*6]; endsequence

   AST_SER_READY: assert property (ser |-> ready)
      else $error("ready low in serial mode");
   AST_SER_BUS: assert property (ser |-> ad_oe_n)
      else $error("bus driven in serial mode");
   AST_RD_RELEASE: assert property (s_rd_quiet |-> ad_oe_n)
      else $error("bus driven without read strobe");
   AST_DS_RELEASE: assert property (s_ds_quiet |-> ad_oe_n)
      else $error("bus driven without read data strobe");
   AST_ACK_END: assert property (s_ds_off |-> ack_n)
      else $error("ack held after strobe end");
   AST_ACK_MODE: assert property (!ack_n |-> dir)
      else $error("ack outside direction mode");
   AST_ACK_READY: assert property ($fell(ack_n) |-> $rose(ready))
      else $error("ack not at access end");
   AST_READY_CAUSE: assert property ($fell(ready) |->
      $past(!wr_n || !rd_n || !moto_data_strobe_n, 1))
      else $error("ready fell without strobe");
   AST_READY_LEN: assert property (!ready |-> lo_cnt < ACC_CYC)
      else $error("ready low too long");
   AST_IRQ_DRIVE: assert property (irq_out |-> !irq_oe_n)
      else $error("irq high while not driven");
   AST_CS_IDLE: assert property (s_cs_off |-> ready && ack_n && ad_oe_n)
      else $error("activity without chip select");
endmodule

bind hcpi_top hcpi_monitor #(.ACC_CYC(ACC_CYC)) mon (.clk, .resetn, .mode_sel, .cs_n, .wr_n,
   .rd_n, .moto_data_strobe_n, .rw_sel, .ready, .ack_n, .ad_oe_n, .irq_out, .irq_oe_n);

/* File: tb/hcpi_host.sv */
`timescale 1ns/1ps
`include "hcpi_consts.svh"

module hcpi_host (
   // Clock and mode
   input wire logic clk,
   input wire logic [1:0] mode_sel,
   // Device answers
   input wire logic ready,
   input wire logic ack_n,
   input wire logic ad_oe_n,
   input wire logic [7:0] ad_out,
   input wire logic ser_out,
   // Host strobes and bus
   output logic cs_n,
   output logic sclk,
   output logic ser_in,
   output logic addr_latch_en,
   output logic addr_strobe_m,
   output logic wr_n,
   output logic rd_n,
   output logic moto_data_strobe_n,
   output logic rw_sel,
   output logic [7:0] ad_in,
   // Read result
   output logic rdv,
   output logic [7:0] rdq
);
   logic [7:0] drv;
   assign ad_in = ad_oe_n ? drv : ad_out;
   initial begin
      {cs_n, wr_n, rd_n, moto_data_strobe_n, rw_sel} = 5'h1f;
      {sclk, ser_in} = 2'h0;
      {addr_latch_en, addr_strobe_m, rdv, drv, rdq} = 19'h00000;
   end

   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      @(negedge clk);
      cs_n = 1'b0;
      drv = a;
      addr_latch_en = 1'b1;
      addr_strobe_m = 1'b1;
      repeat (4) @(negedge clk);
      addr_latch_en = 1'b0;
      addr_strobe_m = 1'b0;
      repeat (4) @(negedge clk);
      // A released bus shows the inverse of the address, never a stale match.
      drv = w ? d : ~a;
      rw_sel = ~w;
      if (mode_sel == `HCPI_MODE_WRSTB) {wr_n, rd_n} = {~w, w};
      else moto_data_strobe_n = 1'b0;
      n = 0;
      do begin @(posedge clk); n++; end while (ready !== 1'b0 && n < 40);
      do begin @(posedge clk); n++; end
      while (!(ready === 1'b1 && (mode_sel != `HCPI_MODE_DIRSEL || ack_n === 1'b0)) && n < 80);
      rdq = ad_in;
      @(negedge clk);
      {wr_n, rd_n, moto_data_strobe_n} = 3'h7;
      rdv = ~w;
      @(negedge clk);
      rdv = 1'b0;
      repeat (3) @(negedge clk);
      cs_n = 1'b1;
      drv = ~drv;
   endtask

   // Serial frame: read flag, seven address bits, then data, all MSB first.
   task automatic ser(input logic w, input logic fall, input logic [7:0] a, input logic [7:0] d);
      logic [15:0] f;
      logic [7:0] q;
      f = {~w, a[6:0], d};
      q = 8'h00;
      @(negedge clk);
      cs_n = 1'b0;
      repeat (10) @(negedge clk);
      for (int i = 15; i >= 0; i--) begin
         ser_in = f[i];
         repeat (10) @(negedge clk);
         // Each data bit is taken on the edge opposite to the one that launched it.
         if (fall && i < 8) q = {q[6:0], ser_out};
         sclk = 1'b1;
         repeat (10) @(negedge clk);
         if (!fall && i < 8) q = {q[6:0], ser_out};
         sclk = 1'b0;
      end
      repeat (10) @(negedge clk);
      cs_n = 1'b1;
      rdq = q;
      rdv = ~w;
      @(negedge clk);
      rdv = 1'b0;
   endtask
endmodule

/* File: tb/test_host_control_port_irq.sv */
`timescale 1ns/1ps
`include "hcpi_consts.svh"

module test_host_control_port_irq;
   logic clk = 1'b0, resetn = 1'b0, ser_out_edge_sel = 1'b0, sclk, ser_in;
   logic [1:0] mode_sel = `HCPI_MODE_WRSTB;
   logic [15:0] irq_src = 16'h0000;
   logic cs_n, addr_latch_en, addr_strobe_m, wr_n, rd_n, moto_data_strobe_n, rw_sel, rdv;
   logic ser_out, ready, ack_n, ad_oe_n, irq_out, irq_oe_n;
   logic [7:0] ad_in, ad_out, rdq, d;
   logic [7:0] exp_q[$];
   int fails = 0, n_checks = 0, cyc = 0, seed = 32'h03bb;

   hcpi_top dut (.clk, .resetn, .mode_sel, .cs_n, .sclk, .ser_in, .ser_out_edge_sel, .ser_out,
      .ad_in, .ad_out, .ad_oe_n, .addr_latch_en, .wr_n, .rd_n, .ready, .addr_strobe_m,
      .moto_data_strobe_n, .rw_sel, .ack_n, .irq_src, .irq_out, .irq_oe_n);
   hcpi_host host (.clk, .mode_sel, .ready, .ack_n, .ad_oe_n, .ad_out, .ser_out, .cs_n, .sclk,
      .ser_in, .addr_latch_en,
      .addr_strobe_m, .wr_n, .rd_n, .moto_data_strobe_n, .rw_sel, .ad_in, .rdv, .rdq);

   always #2 clk = ~clk;

   task print_verdict;
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task cmp(input logic [7:0] g, input logic [7:0] e);
      n_checks++;
      if (g !== e) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   // The run needs under three thousand cycles; eight thousand means a hang.
   always @(posedge clk) begin
      cyc++;
      if (cyc == 8000) begin
         fails++;
         print_verdict();
      end
   end

   always @(posedge clk) begin
      if (rdv === 1'b1) cmp(rdq, exp_q.pop_front());
   end

   task rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      host.acc(1'b0, a, 8'h00);
   endtask

   task wr(input logic [7:0] a, input logic [7:0] v);
      host.acc(1'b1, a, v);
   endtask

   task chk_irq(input logic [1:0] e, input logic [1:0] m);
      repeat (3) @(negedge clk);
      cmp({6'h00, {irq_oe_n, irq_out} & m}, {6'h00, e});
   endtask

   task start(input logic [1:0] m);
      @(negedge clk);
      resetn = 1'b0;
      mode_sel = m;
      repeat (8) @(negedge clk);
      resetn = 1'b1;
      repeat (4) @(negedge clk);
   endtask

   initial begin
      start(`HCPI_MODE_WRSTB);
      rd(`HCPI_OFS_GCFG, `HCPI_GCFG_RST);
      rd(`HCPI_OFS_MASK0, `HCPI_MASK_RST);
      rd(8'h07, 8'h00);
      d = $random(seed);
      wr(`HCPI_OFS_MASK1, d);
      rd(`HCPI_OFS_MASK1, d);
      $display("test registers done");
      @(negedge clk);
      irq_src[9] = 1'b1;
      @(negedge clk);
      irq_src = 16'h0000;
      rd(`HCPI_OFS_STAT1, 8'h02);
      wr(`HCPI_OFS_MASK1, 8'hff);
      chk_irq(2'h0, 2'h3);
      wr(`HCPI_OFS_MASK1, 8'hfd);
      chk_irq(2'h1, 2'h3);
      wr(`HCPI_OFS_GCFG, {6'h00, `HCPI_IRQ_PP_LOW});
      chk_irq(2'h0, 2'h3);
      wr(`HCPI_OFS_GCFG, 8'h02);
      chk_irq(2'h0, 2'h3);
      wr(`HCPI_OFS_STAT1, 8'h02);
      chk_irq(2'h2, 2'h2);
      $display("test interrupt done");
      start(`HCPI_MODE_DIRSEL);
      d = $random(seed);
      wr(`HCPI_OFS_MASK0, d);
      rd(`HCPI_OFS_MASK0, d);
      rd(`HCPI_OFS_STAT0, 8'h00);
      $display("test direction mode done");
      start(`HCPI_MODE_SERIAL);
      ser_out_edge_sel = 1'b1;
      d = $random(seed);
      host.ser(1'b1, ser_out_edge_sel, `HCPI_OFS_MASK0, d);
      exp_q.push_back(d);
      host.ser(1'b0, ser_out_edge_sel, `HCPI_OFS_MASK0, 8'h00);
      @(negedge clk);
      ser_out_edge_sel = 1'b0;
      exp_q.push_back(d);
      host.ser(1'b0, ser_out_edge_sel, `HCPI_OFS_MASK0, 8'h00);
      $display("test serial mode done");
      print_verdict();
   end
endmodule
